// *** hw/pic_ctrl.sv ***
/*
 * Eight-input priority interrupt controller with a classic Wishbone slave.
 * Assumes requests come from same-clock logic; a single clock, sync reset.
 */
// The Wishbone slave port and the placing of the registers are this design's own decisions.
module pic_ctrl
    import pic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [DAT_W-1:0] dat_i,
    output logic [DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic [3:0] terminal_count_i,
    input wire logic [1:0] prod_term_req_i,
    input wire logic [1:0] macrocell_req_i,
    output logic global_irq_logic_feedback_o,
    output logic port_e_pin_2_o,
    output logic port_e_pin_2_oe_n_o
);

    // =========================================================
    // Registers
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] sense_q;
    logic [7:0] sense_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic ack_q;
    logic [DAT_W-1:0] dat_q;
    logic irq_q;
    logic pin_q;
    logic oe_n_q;

    pic_lat_if lat ();

    // =========================================================
    // Request routing into fixed slots
    assign lat.req[TC_BASE +: 4] = terminal_count_i;
    assign lat.req[PT_BASE +: 2] = prod_term_req_i;
    assign lat.req[MC_BASE +: 2] = macrocell_req_i;
    assign lat.mask = mask_q;
    assign lat.sense = sense_q;

    pic_req_latch u_latch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .lat(lat)
    );

    // =========================================================
    // Priority encoder over unmasked pending bits
    wire [7:0] pm = lat.pend & mask_q;
    wire any = |pm;
    wire [VEC_W-1:0] vec = pm[7] ? 3'h7 :
        pm[6] ? 3'h6 :
        pm[5] ? 3'h5 :
        pm[4] ? 3'h4 :
        pm[3] ? 3'h3 :
        pm[2] ? 3'h2 :
        pm[1] ? 3'h1 : 3'h0;

    // =========================================================
    // Wishbone decode; access completes on the edge raising ack
    wire [7:0] idx = adr_i[9:2];
    wire go = cyc_i & stb_i & ~ack_q;
    wire rd = go & ~we_i;
    wire wr = go & we_i & sel_i[0];
    wire hit_prio = idx == IDX_PRIO;
    wire hit_latch = idx == IDX_LATCH;
    wire hit_sense = idx == IDX_SENSE;
    wire hit_mask = idx == IDX_MASK;
    wire hit_rdclr = idx == IDX_RDCLR;
    wire hit_ctrl = idx == IDX_CTRL;

    // Read side effects: status read clears what it reports
    wire rd_vec = rd & hit_prio & any;
    assign lat.clr_vec = rd_vec ? (8'h01 << vec) : 8'h00;
    assign lat.clr_edge = rd & hit_rdclr;

    // Write paths; only byte lane 0 carries data
    assign mask_d = (wr & hit_mask) ? dat_i[7:0] : mask_q;
    assign sense_d = (wr & hit_sense) ? dat_i[7:0] : sense_q;
    assign ctrl_d = (wr & hit_ctrl) ? dat_i[7:0] : ctrl_q;

    // Read mux; unmapped and read-clear locations return zero
    wire [7:0] rbyte = hit_prio ? {5'h00, vec} :
        hit_latch ? lat.pend :
        hit_sense ? sense_q :
        hit_mask ? mask_q :
        hit_ctrl ? ctrl_q : 8'h00;

    // Global interrupt; pin only driven when its special function is on
    wire pin_drv_en = ctrl_q[CTRL_PIN_DRV_BIT];

    // =========================================================
    // Register file and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= RST_MASK;
            sense_q <= RST_SENSE;
            ctrl_q <= RST_CTRL;
            ack_q <= 1'b0;
            dat_q <= '0;
        end else if (ce_i) begin
            mask_q <= mask_d;
            sense_q <= sense_d;
            ctrl_q <= ctrl_d;
            ack_q <= go;
            dat_q <= rd ? {24'h000000, rbyte} : '0;
        end
    end

    // Outputs registered so the pin never sees decode glitches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (ce_i) begin
            irq_q <= any;
            pin_q <= any & pin_drv_en;
            oe_n_q <= ~pin_drv_en;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign global_irq_logic_feedback_o = irq_q;
    assign port_e_pin_2_o = pin_q;
    assign port_e_pin_2_oe_n_o = oe_n_q;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Named steps of a bus access
    sequence s_mask_wr;
        ce_i && wr && hit_mask;
    endsequence

    sequence s_vec_rd;
        ce_i && rd_vec && !lat.set[vec];
    endsequence

    sequence s_rdclr;
        ce_i && rd && hit_rdclr && !(|(lat.set & ~sense_q));
    endsequence

    property p_reset_clear;
        $past(rst_i) |-> mask_q == 8'h00 && sense_q == 8'h00 && lat.pend == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Registers not clear after reset");

    property p_mask_wr;
        s_mask_wr |=> mask_q == $past(dat_i[7:0]);
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("Mask write not stored");

    property p_edge_cap;
        ce_i && lat.req[0] && !$past(lat.req[0]) && mask_q[0] && !sense_q[0]
            && $past(ce_i) |=> lat.pend[0];
    endproperty
    a_edge_cap: assert property (p_edge_cap)
        else $error("Rising edge not latched");

    property p_masked_ignored;
        ce_i && !mask_q[1] && !lat.pend[1] |=> !lat.pend[1];
    endproperty
    a_masked_ignored: assert property (p_masked_ignored)
        else $error("Masked request captured");

    property p_top_prio;
        pm[7] |-> vec == 3'h7;
    endproperty
    a_top_prio: assert property (p_top_prio)
        else $error("Input 7 not given top priority");

    property p_encoder;
        any |-> (pm >> vec) == 8'h01;
    endproperty
    a_encoder: assert property (p_encoder)
        else $error("Encoder not reporting highest pending");

    property p_vec_clear;
        s_vec_rd |=> !lat.pend[$past(vec)];
    endproperty
    a_vec_clear: assert property (p_vec_clear)
        else $error("Status read did not clear reported bit");

    property p_rdclr_edge;
        s_rdclr |=> (lat.pend & ~sense_q) == 8'h00;
    endproperty
    a_rdclr_edge: assert property (p_rdclr_edge)
        else $error("Read clear left edge bits pending");

    property p_level_hold;
        ce_i && rd && hit_rdclr
            |=> &(lat.pend | ~$past(sense_q & mask_q & lat.req));
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("Level pending bit cleared while active");

    property p_global_irq;
        ce_i ##1 ce_i |-> global_irq_logic_feedback_o == $past(any);
    endproperty
    a_global_irq: assert property (p_global_irq)
        else $error("Global interrupt does not follow pending");

    property p_status_upper;
        ce_i && rd && hit_prio |=> ack_o && dat_o[31:3] == '0;
    endproperty
    a_status_upper: assert property (p_status_upper)
        else $error("Status upper bits not zero");

    // Capture, hold and readback of the request latch, plus sense write, pin drive and empty status read
    property p_level_cap;
        ce_i |=> &(lat.pend | ~$past(sense_q & mask_q & lat.req));
    endproperty
    a_level_cap: assert property (p_level_cap)
        else $error("Active level request not pending");

    property p_new_unmasked;
        ce_i |=> (lat.pend & ~$past(lat.pend) & ~$past(mask_q)) == 8'h00;
    endproperty
    a_new_unmasked: assert property (p_new_unmasked)
        else $error("Pending bit appeared on a masked input");

    property p_pend_hold;
        ce_i && !rd |=> (lat.pend & $past(lat.pend)) == $past(lat.pend);
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("Pending bit dropped without a read");

    property p_latch_read;
        ce_i && rd && hit_latch |=> ack_o && dat_o == {24'h000000, $past(lat.pend)};
    endproperty
    a_latch_read: assert property (p_latch_read)
        else $error("Latch read does not show pending bits");

    property p_sense_wr;
        ce_i && wr && hit_sense |=> sense_q == $past(dat_i[7:0]);
    endproperty
    a_sense_wr: assert property (p_sense_wr)
        else $error("Sense write not stored");

    property p_pin_drive;
        ce_i ##1 ce_i |-> port_e_pin_2_o == ($past(any) && $past(pin_drv_en))
            && port_e_pin_2_oe_n_o == !$past(pin_drv_en);
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("Pin does not follow global interrupt");

    property p_route;
        lat.req == {macrocell_req_i, prod_term_req_i, terminal_count_i};
    endproperty
    a_route: assert property (p_route)
        else $error("Request inputs routed to wrong slots");

    property p_vec_none;
        ce_i && rd && hit_prio && !any |=> dat_o == 32'h00000000;
    endproperty
    a_vec_none: assert property (p_vec_none)
        else $error("Status nonzero with nothing pending");

    // Enable low must freeze everything, bus answer included
    property p_freeze;
        !ce_i |=> $stable(lat.pend) && $stable(mask_q) && $stable(sense_q) && $stable(ack_o);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("State moved while enable low");

endmodule

// *** hw/pic_lat_if.sv ***
/*
 * Carrier between the controller core and its request latch bank.
 * Assumes both ends run on the same clock.
 */
interface pic_lat_if;
    import pic_pkg::*;

    logic [NUM_REQ-1:0] req;
    logic [NUM_REQ-1:0] mask;
    logic [NUM_REQ-1:0] sense;
    logic clr_edge;
    logic [NUM_REQ-1:0] clr_vec;
    logic [NUM_REQ-1:0] pend;
    logic [NUM_REQ-1:0] set;

    // =========================================================
    // Core drives controls, latch bank reports state
    modport ctl (output req, mask, sense, clr_edge, clr_vec, input pend, set);
    modport lat (input req, mask, sense, clr_edge, clr_vec, output pend, set);
endinterface

// *** hw/pic_pkg.sv ***
/*
 * Shared constants for the eight-input priority interrupt controller:
 * register indices, reset values, field positions and request slot layout.
 * Assumes a 32-bit classic Wishbone bus; byte address is four times an index.
 */
package pic_pkg;

    // =========================================================
    // Widths
    localparam int unsigned NUM_REQ = 8;
    localparam int unsigned VEC_W = 3;
    localparam int unsigned ADR_W = 10;
    localparam int unsigned DAT_W = 32;

    // =========================================================
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_PRIO = 8'hd0;
    localparam logic [7:0] IDX_LATCH = 8'hd1;
    localparam logic [7:0] IDX_SENSE = 8'hd2;
    localparam logic [7:0] IDX_MASK = 8'hd3;
    localparam logic [7:0] IDX_RDCLR = 8'hd4;
    localparam logic [7:0] IDX_CTRL = 8'hd8;

    // =========================================================
    // Reset values
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_SENSE = 8'h00;
    localparam logic [7:0] RST_PEND = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // =========================================================
    // Field positions
    localparam int unsigned CTRL_PIN_DRV_BIT = 0;
    localparam int unsigned TC_BASE = 0;
    localparam int unsigned PT_BASE = 4;
    localparam int unsigned MC_BASE = 6;

endpackage

// *** hw/pic_req_latch.sv ***
/*
 * Request latch bank: per-input edge or level sensing and pending bits.
 * Assumes requests come from logic on the same clock, so no synchroniser.
 */
module pic_req_latch
    import pic_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    pic_lat_if.lat lat
);

    logic [NUM_REQ-1:0] prev_q;
    logic [NUM_REQ-1:0] pend_q;
    logic [NUM_REQ-1:0] pend_d;

    // =========================================================
    // Per-bit sense and clear
    for (genvar i = 0; i < NUM_REQ; i++) begin : g_bit
        wire rise = lat.req[i] & ~prev_q[i];
        wire hit = lat.sense[i] ? lat.req[i] : rise;
        wire clr = (lat.clr_edge & ~lat.sense[i]) | lat.clr_vec[i];
        // Masked inputs never capture; set beats clear
        assign lat.set[i] = hit & lat.mask[i];
        assign pend_d[i] = lat.set[i] | (pend_q[i] & ~clr);
    end

    // Previous input sample and pending latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= '0;
            pend_q <= RST_PEND;
        end else if (ce_i) begin
            prev_q <= lat.req;
            pend_q <= pend_d;
        end
    end

    assign lat.pend = pend_q;

endmodule

// *** testbench/pic_host_model.sv ***
/*
 * Host model: a classic Wishbone master that reads and writes the
 * interrupt controller registers one access at a time.
 * Assumes one shared clock and a slave that acks each access once.
 */
module pic_host_model
    import pic_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [DAT_W-1:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [ADR_W-1:0] adr_o,
    output logic [3:0] sel_o,
    output logic [DAT_W-1:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // =========================================================
    // Idle bus at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = '0;
        sel_o = 4'h0;
        dat_o = '0;
    end

    // =========================================================
    // One access; ack and read data are taken on the same rising edge
    task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'h1;
        dat_o <= {24'h000000, wd};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rd = dat_i[7:0];
        cyc_o <= 1'b0; // Released only after the acking edge
        stb_o <= 1'b0;
        we_o <= 1'b0;
    endtask
endmodule

// *** testbench/test_pic_ctrl.sv ***
/*
 * Self-checking bench for the priority interrupt controller.
 * Assumes the host model drives the register bus; requests come from here.
 */
module test_pic_ctrl
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cyc, stb, we, ack, irq, pin, oe_n;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] wdat, rdat;
    logic [7:0] req = 8'h00;
    logic [7:0] v;
    int miscompares = 0;
    int check_count = 0;
    // Rows: sense, mask, request, expected latch, expected vector
    logic [39:0] rows [6] = '{40'h00ff818107, 40'h000ff30301, 40'hffff242405,
                              40'h00ff010100, 40'h0000ff0000, 40'h00ff505006};

    always #5 clk = ~clk;

    pic_ctrl pic_ctrl_inst (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .terminal_count_i(req[3:0]),
        .prod_term_req_i(req[5:4]), .macrocell_req_i(req[7:6]), .global_irq_logic_feedback_o(irq),
        .port_e_pin_2_o(pin), .port_e_pin_2_oe_n_o(oe_n));
    pic_host_model pic_host_model_inst (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // =========================================================
    // Shared checks and bus helpers
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        pic_host_model_inst.access(1'b0, idx, 8'h00, v);
        chk($sformatf("register %h", idx), exp, v);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        pic_host_model_inst.access(1'b1, idx, d, v);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        req <= 8'h00;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // =========================================================
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    // =========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk(IDX_MASK, 8'h00);
        rchk(IDX_SENSE, 8'h00);
        rchk(IDX_LATCH, 8'h00);
        rchk(IDX_CTRL, 8'h00);
        @(negedge clk);
        chk("pin enable", 8'h01, {7'h00, oe_n});
        wr(IDX_MASK, 8'ha5);
        rchk(IDX_MASK, 8'ha5);
        rchk(8'h55, 8'h00);
        // Table loop; a reset between rows keeps leftovers from leaking
        foreach (rows[i]) begin
            do_reset();
            wr(IDX_SENSE, rows[i][39:32]);
            wr(IDX_MASK, rows[i][31:24]);
            @(posedge clk);
            req <= rows[i][23:16];
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("global irq", {7'h00, |rows[i][15:8]}, {7'h00, irq});
            chk("pin", 8'h00, {7'h00, pin});
            rchk(IDX_LATCH, rows[i][15:8]);
            rchk(IDX_PRIO, rows[i][7:0]);
        end
        // Edge bit pulsed once, level bit held
        do_reset();
        wr(IDX_SENSE, 8'h02);
        wr(IDX_MASK, 8'h03);
        @(posedge clk);
        req <= 8'h03;
        @(posedge clk);
        req <= 8'h02;
        repeat (3) @(posedge clk);
        rchk(IDX_LATCH, 8'h03);
        rchk(IDX_RDCLR, 8'h00);
        rchk(IDX_LATCH, 8'h02);
        rchk(IDX_PRIO, 8'h01);
        // Mid-run reset wipes a live level bit
        do_reset();
        rchk(IDX_LATCH, 8'h00);
        rchk(IDX_SENSE, 8'h00);
        // Enable low: a pulse that comes and goes while frozen is never seen
        wr(IDX_MASK, 8'h01);
        @(posedge clk);
        ce <= 1'b0;
        req <= 8'h01;
        @(posedge clk);
        req <= 8'h00;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        rchk(IDX_LATCH, 8'h00);
        @(posedge clk);
        req <= 8'h01;
        repeat (3) @(posedge clk);
        rchk(IDX_LATCH, 8'h01);
        // Service in descending order with the pin driven
        do_reset();
        wr(IDX_MASK, 8'hff);
        wr(IDX_CTRL, 8'h01);
        @(posedge clk);
        req <= 8'h90;
        @(posedge clk);
        req <= 8'h00;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("pin", 8'h01, {7'h00, pin});
        chk("pin enable", 8'h00, {7'h00, oe_n});
        rchk(IDX_PRIO, 8'h07);
        rchk(IDX_PRIO, 8'h04);
        rchk(IDX_LATCH, 8'h00);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("global irq", 8'h00, {7'h00, irq});
        conclude();
    end
endmodule
